// ===== rtl/tap_params.svh
/*
  Constants of the boundary-scan test port: lengths, opcodes,
  capture values and timing counts.
  Assumes inclusion by the package and the port module.
*/
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

`define IR_LEN          10
`define IR_CAPTURE      10'h001
`define BSR_LEN         96
`define ID_LEN          32
`define USERCODE_LEN    32
`define UES_LEN         16
`define PROG_W          16
`define PROG_DR_LEN     17

`define OP_EXTEST       10'h000
`define OP_SAMPLE       10'h005
`define OP_IDCODE       10'h059
`define OP_USERCODE     10'h079
`define OP_UES_READ     10'h00E
`define OP_ISP_ENTER    10'h2CC
`define OP_ISP_PROGRAM  10'h2E1
`define OP_ISP_ERASE    10'h2F2
`define OP_ISP_EXIT     10'h201
`define OP_BYPASS       10'h3FF

`define SYS_CLK_KHZ     40000
`define ERASE_PULSE_MS  100
`define ERASE_CNT_W     22

`define PIN_TCK         0
`define PIN_TMS         1
`define PIN_TDI         2
`define PIN_EN          3

`endif

// ===== rtl/tap_pkg.sv
/*
  Types of the boundary-scan test port: controller states, data
  register selection and the packed state of the port module.
  Assumes tap_params.svh is on the include path.
*/
`default_nettype none
`include "tap_params.svh"

package tap_pkg;

  typedef enum logic [3:0] {
    ST_RESET    = 4'h0,
    ST_IDLE     = 4'h1,
    ST_SEL_DR   = 4'h3,
    ST_CAP_DR   = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EX1_DR   = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EX2_DR   = 4'h4,
    ST_UPD_DR   = 4'hC,
    ST_SEL_IR   = 4'hD,
    ST_CAP_IR   = 4'hF,
    ST_SHIFT_IR = 4'hE,
    ST_EX1_IR   = 4'hA,
    ST_PAUSE_IR = 4'hB,
    ST_EX2_IR   = 4'h9,
    ST_UPD_IR   = 4'h8
  } tap_state_t;

  typedef enum logic [2:0] {
    SEL_BYP, SEL_BSR, SEL_ID, SEL_USER, SEL_UES, SEL_PROG
  } dr_sel_t;

  typedef struct packed {
    logic [3:0]              s1;
    logic [3:0]              s2;
    logic [3:0]              s3;
    logic [3:0]              flt;
    logic [`BSR_LEN-1:0]     p1;
    logic [`BSR_LEN-1:0]     p2;
    logic [`BSR_LEN-1:0]     p3;
    logic [`BSR_LEN-1:0]     pflt;
    logic                    tck_q;
    tap_state_t              st;
    logic [`IR_LEN-1:0]      ir_sh;
    logic [`IR_LEN-1:0]      ir;
    logic [`BSR_LEN-1:0]     dr_sh;
    logic [`BSR_LEN-1:0]     bsr_upd;
    logic [`BSR_LEN-1:0]     pad;
    logic                    tdo;
    logic                    tdo_oe_n;
    logic                    isp_mode;
    logic                    erase_on;
    logic [`ERASE_CNT_W-1:0] erase_cnt;
    logic                    pend;
    logic [`PROG_W-1:0]      pend_d;
    logic                    out_v;
    logic [`PROG_W-1:0]      out_d;
    logic                    sp_v;
    logic [`PROG_W-1:0]      sp_d;
    logic [2:0]              user_in;
  } tap_regs_t;

endpackage

`default_nettype wire

// ===== rtl/boundary_scan_test_port.sv
/*
  Boundary-scan test port sampled on the system clock: controller,
  instruction register, data registers, in-system programming word
  path with a two-entry buffer, and erase pulse timer.
  Assumes TCK, TMS, TDI, enable and pin levels are asynchronous and
  TCK is far slower than SYS_CLK; the TDO wire is resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tap_params.svh"

module boundary_scan_test_port
  import tap_pkg::*;
#(
  parameter logic             USERCODE_VARIANT = 1'b1,
  parameter logic [3:0]       ID_VERSION       = 4'h2,
  // Arbitrary neutral identity value
  parameter logic [26:0]      ID_BODY          = 27'h2A5_5A5A,
  parameter logic [31:0]      USERCODE         = 32'h0000_0000,
  parameter logic [15:0]      UES_VALUE        = 16'h0000,
  parameter int unsigned      ERASE_CYCLES     =
    `ERASE_PULSE_MS * `SYS_CLK_KHZ
) (
  input  wire logic                SYS_CLK,
  input  wire logic                NRST,
  input  wire logic                TCK,
  input  wire logic                TMS,
  input  wire logic                TDI,
  input  wire logic                JTAG_ENABLE,
  input  wire logic                USER_TDO_OUT,
  input  wire logic                USER_TDO_OE_N,
  input  wire logic [`BSR_LEN-1:0] PIN_IN,
  input  wire logic [`BSR_LEN-1:0] CORE_OUT,
  input  wire logic [`PROG_W-1:0]  PROG_RDATA,
  input  wire logic                PROG_READY,
  output logic                     TDO,
  output logic                     TDO_OE_N,
  output logic [`BSR_LEN-1:0]      PAD_OUT,
  output logic [2:0]               USER_IN,
  output logic                     ISP_MODE,
  output logic                     ERASE_PULSE,
  output logic                     PROG_VALID,
  output logic [`PROG_W-1:0]       PROG_DATA
);

  localparam logic [31:0] IDCODE_VAL = {ID_VERSION, ID_BODY, 1'b1};
  localparam logic [`ERASE_CNT_W-1:0] ERASE_LAST =
    `ERASE_CNT_W'(ERASE_CYCLES - 1);
  localparam logic [`ERASE_CNT_W-1:0] CNT_ONE =
    {{(`ERASE_CNT_W-1){1'b0}}, 1'b1};

  tap_regs_t r_ff;
  tap_regs_t nxt_r;
  dr_sel_t   sel;
  logic      tck_rise;
  logic      tck_fall;
  logic      tms;
  logic      tdi;
  logic      enabled;
  logic      pop;
  logic      push_ok;

  assign tck_rise = r_ff.flt[`PIN_TCK] & ~r_ff.tck_q;
  assign tck_fall = ~r_ff.flt[`PIN_TCK] & r_ff.tck_q;
  assign tms      = r_ff.flt[`PIN_TMS];
  assign tdi      = r_ff.flt[`PIN_TDI];
  assign enabled  = r_ff.flt[`PIN_EN];
  assign pop      = r_ff.out_v & PROG_READY;
  // Filling side ready: spare slot free
  assign push_ok  = r_ff.pend & ~r_ff.sp_v;

  // Data register steering from the held instruction
  always_comb begin
    unique case (r_ff.ir)
      `OP_SAMPLE, `OP_EXTEST: sel = SEL_BSR;
      `OP_IDCODE:             sel = SEL_ID;
      `OP_USERCODE:           sel = USERCODE_VARIANT ? SEL_USER : SEL_BYP;
      `OP_UES_READ:           sel = USERCODE_VARIANT ? SEL_BYP : SEL_UES;
      `OP_ISP_PROGRAM:        sel = SEL_PROG;
      default:                sel = SEL_BYP;
    endcase
  end

  always_comb begin
    nxt_r = r_ff;
    // Three-stage sampling; a change counts once stages two and three agree
    nxt_r.s1   = {JTAG_ENABLE, TDI, TMS, TCK};
    nxt_r.s2   = r_ff.s1;
    nxt_r.s3   = r_ff.s2;
    nxt_r.flt  = (r_ff.s2 & r_ff.s3) | ((r_ff.s2 ^ r_ff.s3) & r_ff.flt);
    nxt_r.p1   = PIN_IN;
    nxt_r.p2   = r_ff.p1;
    nxt_r.p3   = r_ff.p2;
    nxt_r.pflt = (r_ff.p2 & r_ff.p3) | ((r_ff.p2 ^ r_ff.p3) & r_ff.pflt);
    nxt_r.tck_q = r_ff.flt[`PIN_TCK];

    // Controller moves only on a filtered TCK rise, except the forced reset while the port is disabled
    if (tck_rise) begin
      unique case (r_ff.st)
        ST_RESET:    nxt_r.st = tms ? ST_RESET : ST_IDLE;
        ST_IDLE:     nxt_r.st = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR:   nxt_r.st = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR:   nxt_r.st = tms ? ST_EX1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: nxt_r.st = tms ? ST_EX1_DR : ST_SHIFT_DR;
        ST_EX1_DR:   nxt_r.st = tms ? ST_UPD_DR : ST_PAUSE_DR;
        ST_PAUSE_DR: nxt_r.st = tms ? ST_EX2_DR : ST_PAUSE_DR;
        ST_EX2_DR:   nxt_r.st = tms ? ST_UPD_DR : ST_SHIFT_DR;
        ST_UPD_DR:   nxt_r.st = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR:   nxt_r.st = tms ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR:   nxt_r.st = tms ? ST_EX1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: nxt_r.st = tms ? ST_EX1_IR : ST_SHIFT_IR;
        ST_EX1_IR:   nxt_r.st = tms ? ST_UPD_IR : ST_PAUSE_IR;
        ST_PAUSE_IR: nxt_r.st = tms ? ST_EX2_IR : ST_PAUSE_IR;
        ST_EX2_IR:   nxt_r.st = tms ? ST_UPD_IR : ST_SHIFT_IR;
        ST_UPD_IR:   nxt_r.st = tms ? ST_SEL_DR : ST_IDLE;
      endcase

      if (r_ff.st == ST_CAP_IR) begin
        nxt_r.ir_sh = `IR_CAPTURE;
      end
      if (r_ff.st == ST_SHIFT_IR) begin
        nxt_r.ir_sh = {tdi, r_ff.ir_sh[`IR_LEN-1:1]};
      end

      // Capture loads the selected register; unused upper bits stay zero
      if (r_ff.st == ST_CAP_DR) begin
        nxt_r.dr_sh = '0;
        unique case (sel)
          SEL_BYP:  nxt_r.dr_sh[0] = 1'b0;
          SEL_BSR:  nxt_r.dr_sh = r_ff.pflt;
          SEL_ID:   nxt_r.dr_sh[`ID_LEN-1:0] = IDCODE_VAL;
          SEL_USER: nxt_r.dr_sh[`USERCODE_LEN-1:0] = USERCODE;
          SEL_UES:  nxt_r.dr_sh[`UES_LEN-1:0] = UES_VALUE;
          SEL_PROG: nxt_r.dr_sh[`PROG_DR_LEN-1:0] =
            {r_ff.pend, PROG_RDATA};
          default:  nxt_r.dr_sh[0] = 1'b0;
        endcase
      end

      if (r_ff.st == ST_SHIFT_DR) begin
        unique case (sel)
          SEL_BYP:  nxt_r.dr_sh[0] = tdi;
          SEL_BSR:  nxt_r.dr_sh = {tdi, r_ff.dr_sh[`BSR_LEN-1:1]};
          SEL_ID, SEL_USER:
            nxt_r.dr_sh[31:0] = {tdi, r_ff.dr_sh[31:1]};
          SEL_UES:
            nxt_r.dr_sh[`UES_LEN-1:0] =
              {tdi, r_ff.dr_sh[`UES_LEN-1:1]};
          SEL_PROG:
            nxt_r.dr_sh[`PROG_DR_LEN-1:0] =
              {tdi, r_ff.dr_sh[`PROG_DR_LEN-1:1]};
          default:  nxt_r.dr_sh[0] = tdi;
        endcase
      end
    end

    if (tck_fall) begin
      // Output changes on the falling edge so the far end samples mid-bit
      nxt_r.tdo_oe_n = 1'b1;
      if (r_ff.st == ST_SHIFT_DR) begin
        nxt_r.tdo      = r_ff.dr_sh[0];
        nxt_r.tdo_oe_n = 1'b0;
      end
      if (r_ff.st == ST_SHIFT_IR) begin
        nxt_r.tdo      = r_ff.ir_sh[0];
        nxt_r.tdo_oe_n = 1'b0;
      end
      if (r_ff.st == ST_RESET) begin
        nxt_r.ir = `OP_IDCODE;
      end
      if (r_ff.st == ST_UPD_IR) begin
        nxt_r.ir = r_ff.ir_sh;
        unique case (r_ff.ir_sh)
          `OP_ISP_ENTER: nxt_r.isp_mode = 1'b1;
          // Exit refused while a pulse runs; the cells must see it whole
          `OP_ISP_EXIT:  nxt_r.isp_mode = r_ff.erase_on;
          `OP_ISP_ERASE: begin
            if (r_ff.isp_mode && !r_ff.erase_on) begin
              nxt_r.erase_on  = 1'b1;
              nxt_r.erase_cnt = ERASE_LAST;
            end
          end
          default: ;
        endcase
      end
      if (r_ff.st == ST_UPD_DR) begin
        if (sel == SEL_BSR) begin
          nxt_r.bsr_upd = r_ff.dr_sh;
        end
        // A busy word is refused; capture shows busy so none is lost
        if (sel == SEL_PROG && r_ff.isp_mode && !r_ff.pend) begin
          nxt_r.pend   = 1'b1;
          nxt_r.pend_d = r_ff.dr_sh[`PROG_W-1:0];
        end
      end
    end

    // Boundary pads: core path unless external test holds the chain
    nxt_r.pad = (r_ff.ir == `OP_EXTEST) ? r_ff.bsr_upd : CORE_OUT;

    // Pulse length loaded at start; counts down to zero
    if (r_ff.erase_on) begin
      if (r_ff.erase_cnt == '0) begin
        nxt_r.erase_on = 1'b0;
      end else begin
        nxt_r.erase_cnt = r_ff.erase_cnt - CNT_ONE;
      end
    end

    // Two-entry buffer toward the programming core
    if (pop) begin
      nxt_r.out_v = 1'b0;
    end
    if (r_ff.sp_v && !nxt_r.out_v) begin
      nxt_r.out_v = 1'b1;
      nxt_r.out_d = r_ff.sp_d;
      nxt_r.sp_v  = 1'b0;
    end
    if (push_ok) begin
      if (!nxt_r.out_v) begin
        nxt_r.out_v = 1'b1;
        nxt_r.out_d = r_ff.pend_d;
      end else begin
        nxt_r.sp_v = 1'b1;
        nxt_r.sp_d = r_ff.pend_d;
      end
      nxt_r.pend = 1'b0;
    end

    // Port disabled: held in reset, pins handed to user logic
    nxt_r.user_in = 3'h0;
    if (!enabled) begin
      nxt_r.st       = ST_RESET;
      nxt_r.ir       = `OP_IDCODE;
      nxt_r.tdo      = USER_TDO_OUT;
      nxt_r.tdo_oe_n = USER_TDO_OE_N;
      nxt_r.user_in  = r_ff.flt[2:0];
    end
  end

  // Reset parks the controller with identification selected
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      r_ff          <= '0;
      r_ff.st       <= ST_RESET;
      r_ff.ir       <= `OP_IDCODE;
      r_ff.tdo_oe_n <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign TDO         = r_ff.tdo;
  assign TDO_OE_N    = r_ff.tdo_oe_n;
  assign PAD_OUT     = r_ff.pad;
  assign USER_IN     = r_ff.user_in;
  assign ISP_MODE    = r_ff.isp_mode;
  assign ERASE_PULSE = r_ff.erase_on;
  assign PROG_VALID  = r_ff.out_v;
  assign PROG_DATA   = r_ff.out_d;

endmodule

`default_nettype wire

// ===== bench/tap_port_sva.sv
/*
  Port checker for the boundary-scan test port.
  Assumes binding onto every boundary_scan_test_port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tap_params.svh"
module tap_port_sva #(
  parameter int unsigned ERASE_CYCLES = 20
) (
  input wire logic                SYS_CLK,
  input wire logic                NRST,
  input wire logic                TCK,
  input wire logic                TMS,
  input wire logic                TDI,
  input wire logic                JTAG_ENABLE,
  input wire logic                USER_TDO_OUT,
  input wire logic                USER_TDO_OE_N,
  input wire logic [`BSR_LEN-1:0] CORE_OUT,
  input wire logic                PROG_READY,
  input wire logic                TDO,
  input wire logic                TDO_OE_N,
  input wire logic [`BSR_LEN-1:0] PAD_OUT,
  input wire logic [2:0]          USER_IN,
  input wire logic                ISP_MODE,
  input wire logic                ERASE_PULSE,
  input wire logic                PROG_VALID,
  input wire logic [`PROG_W-1:0]  PROG_DATA
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  logic [31:0] on_ff;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      on_ff <= 32'h0;
    end else begin
      on_ff <= ERASE_PULSE ? on_ff + 32'h1 : 32'h0;
    end
  end
  sequence s_off;
    !JTAG_ENABLE && $stable({TDI, TMS, TCK, USER_TDO_OUT, USER_TDO_OE_N});
  endsequence
  sequence s_stall;
    PROG_VALID && !PROG_READY;
  endsequence
  a_off_user_in: assert property (
    s_off [*8] |-> USER_IN == {TDI, TMS, TCK}) else $error("user in");
  a_off_user_tdo: assert property (
    s_off [*8] |-> TDO == USER_TDO_OUT && TDO_OE_N == USER_TDO_OE_N)
    else $error("user tdo");
  a_on_user_zero: assert property (
    JTAG_ENABLE [*8] |-> USER_IN == 3'h0) else $error("user in not 0");
  a_off_pad_core: assert property (
    (!JTAG_ENABLE) [*8] |-> PAD_OUT == $past(CORE_OUT))
    else $error("pads not from core");
  a_erase_pulse_len: assert property (
    $fell(ERASE_PULSE) |-> on_ff == ERASE_CYCLES) else $error("erase len");
  a_erase_in_isp: assert property (
    ERASE_PULSE |-> ISP_MODE) else $error("erase outside isp");
  a_stall_hold: assert property (
    s_stall |=> PROG_VALID && $stable(PROG_DATA)) else $error("word lost");
  a_word_in_isp: assert property (
    $rose(PROG_VALID) |-> $past(ISP_MODE)) else $error("word outside isp");
endmodule
bind boundary_scan_test_port tap_port_sva #(
  .ERASE_CYCLES(ERASE_CYCLES)
) chk (
  .SYS_CLK, .NRST, .TCK, .TMS, .TDI, .JTAG_ENABLE, .USER_TDO_OUT,
  .USER_TDO_OE_N, .CORE_OUT, .PROG_READY, .TDO, .TDO_OE_N, .PAD_OUT,
  .USER_IN, .ISP_MODE, .ERASE_PULSE, .PROG_VALID, .PROG_DATA
);
`default_nettype wire

// ===== bench/tap_host_model.sv
/*
  Test controller model driving the scan link.
  Assumes TDO is already resolved with its pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_host_model (
  output logic     TCK,
  output logic     TMS,
  output logic     TDI,
  input wire logic TDO
);
  initial begin
    TCK = 1'b1;
    TMS = 1'b1;
    TDI = 1'b1;
  end
  // TDO read late: it settles some clocks after the fall
  task automatic step(input logic ms, input logic di, output logic r);
    TCK = 1'b0;
    TMS = ms;
    TDI = di;
    #100;
    TCK = 1'b1;
    #99;
    r = TDO;
    #1;
  endtask
  task automatic reset_tap;
    logic b;
    repeat (5) step(1'b1, ~TDI, b);
    step(1'b0, ~TDI, b);
  endtask
  // Idle to idle; TDI toggles outside shifting
  task automatic scan(input logic ir, input int n, input logic [95:0] d,
                      output logic [95:0] q);
    logic b;
    q = 96'h0;
    step(1'b1, ~TDI, b);
    if (ir) step(1'b1, ~TDI, b);
    step(1'b0, ~TDI, b);
    step(1'b0, ~TDI, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    step(1'b1, ~TDI, b);
    step(1'b0, ~TDI, b);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_boundary_scan_test_port.sv
/*
  Self-checking bench of the boundary-scan test port.
  Assumes the host model and the checker compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tap_params.svh"
module tb_boundary_scan_test_port;
  localparam logic [3:0]  VER = 4'h3;
  localparam logic [26:0] BODY = 27'h1234567; // Arbitrary
  localparam logic [31:0] UCODE = 32'h5A3C_96E1;
  localparam logic [15:0] UESV = 16'hC3A5;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        en = 1'b0;
  logic        uout = 1'b0;
  logic        uoen = 1'b1;
  logic        rdy = 1'b0;
  logic [2:0]  ulv = 3'h0;
  logic [15:0] rdata = 16'h0000;
  logic [15:0] lf = 16'h0044;
  logic [95:0] pin = 96'h0;
  logic [95:0] core = 96'h0;
  logic [95:0] q, v, pad;
  logic [15:0] pdata;
  logic [15:0] w [4];
  logic [9:0]  byp [3] = '{`OP_BYPASS, 10'h155, `OP_UES_READ};
  logic [2:0]  uin;
  logic        tdo, oen, in_system_programming, ers, pv, mtck, mtms, mtdi;
  logic        tdo2, oen2;
  logic        alt = 1'b0;
  logic        tck_i, tms_i, tdi_i;
  int          errors = 0;
  int          checks = 0;
  initial forever #12.5 clk = ~clk;
  assign tck_i = en ? mtck : ulv[0];
  assign tms_i = en ? mtms : ulv[1];
  assign tdi_i = en ? mtdi : ulv[2];
  tap_host_model host (.TCK(mtck), .TMS(mtms), .TDI(mtdi),
    .TDO(alt ? (oen2 | tdo2) : (oen | tdo)));
  // Signature variant in lock step; its TDO is read while alt is high
  boundary_scan_test_port #(.USERCODE_VARIANT(1'b0), .UES_VALUE(UESV),
    .ERASE_CYCLES(20)) dut_ues (
    .SYS_CLK(clk), .NRST(nrst), .TCK(tck_i), .TMS(tms_i), .TDI(tdi_i),
    .JTAG_ENABLE(en), .USER_TDO_OUT(uout), .USER_TDO_OE_N(uoen),
    .PIN_IN(pin), .CORE_OUT(core), .PROG_RDATA(rdata), .PROG_READY(rdy),
    .TDO(tdo2), .TDO_OE_N(oen2), .PAD_OUT(), .USER_IN(), .ISP_MODE(),
    .ERASE_PULSE(), .PROG_VALID(), .PROG_DATA());
  boundary_scan_test_port #(.ID_VERSION(VER), .ID_BODY(BODY),
    .USERCODE(UCODE), .ERASE_CYCLES(20)) dut (
    .SYS_CLK(clk), .NRST(nrst), .TCK(tck_i),
    .TMS(tms_i), .TDI(tdi_i), .JTAG_ENABLE(en),
    .USER_TDO_OUT(uout), .USER_TDO_OE_N(uoen), .PIN_IN(pin),
    .CORE_OUT(core), .PROG_RDATA(rdata), .PROG_READY(rdy), .TDO(tdo),
    .TDO_OE_N(oen), .PAD_OUT(pad), .USER_IN(uin), .ISP_MODE(in_system_programming),
    .ERASE_PULSE(ers), .PROG_VALID(pv), .PROG_DATA(pdata));
  task automatic chk(input string s, input logic [95:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic rn(output logic [95:0] r);
    @(negedge clk);
    repeat (6) begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      r = {r[79:0], lf};
    end
  endtask
  task automatic wait_lv(input logic pick, input logic lv);
    for (int i = 0; i < 2000 && (pick ? pv : ers) !== lv; i++)
      @(negedge clk);
    if ((pick ? pv : ers) !== lv) begin
      errors++;
      close_out();
    end
  endtask
  task automatic ir(input logic [9:0] op);
    host.scan(1'b1, 10, {86'h0, op}, q);
    chk("ir capture", q, `IR_CAPTURE);
  endtask
  task automatic dr(input int n, input logic [95:0] d);
    host.scan(1'b0, n, d, q);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) begin
      rn(v);
      {uoen, uout, ulv} = v[4:0];
      core = v;
      repeat (10) @(negedge clk);
      chk("user pins", {uin, oen, tdo}, {ulv, uoen, uout});
      chk("pads", pad, core);
    end
    en = 1'b1;
    repeat (6) @(negedge clk);
    host.reset_tap();
    dr(32, 96'h0);
    chk("id word", q, {VER, BODY, 1'b1});
    foreach (byp[i]) begin
      ir(byp[i]);
      rn(v);
      dr(9, v);
      chk("bypass", q, {v[7:0], 1'b0});
    end
    ir(`OP_USERCODE);
    dr(32, 96'h0);
    chk("user code", q, UCODE);
    alt = 1'b1;
    ir(`OP_UES_READ);
    dr(16, 96'h0);
    chk("signature", q, UESV);
    ir(`OP_USERCODE);
    rn(v);
    dr(9, v);
    chk("no user code", q, {v[7:0], 1'b0});
    alt = 1'b0;
    rn(pin);
    rn(v);
    ir(`OP_SAMPLE);
    dr(96, v);
    chk("sample", q, pin);
    chk("pads kept", pad, core);
    ir(`OP_EXTEST);
    chk("extest drive", pad, v);
    rn(pin);
    dr(96, ~v);
    chk("extest capture", q, pin);
    chk("extest update", pad, ~v);
    ir(`OP_ISP_ENTER);
    chk("isp on", in_system_programming, 1'b1);
    #1ms;
    ir(`OP_ISP_ERASE);
    chk("erase on", ers, 1'b1);
    wait_lv(1'b0, 1'b0);
    ir(`OP_ISP_PROGRAM);
    for (int k = 0; k < 4; k++) begin
      rn(v);
      rdata = v[31:16];
      w[k] = v[15:0];
      dr(17, {80'h0, v[15:0]});
      chk("busy readback", q, {k == 3, rdata});
    end
    chk("head", {pv, pdata}, {1'b1, w[0]});
    for (int k = 0; k < 3; k++) begin
      wait_lv(1'b1, 1'b1);
      chk("word", pdata, w[k]);
      rdy = 1'b1;
      @(negedge clk);
      rdy = 1'b0;
    end
    repeat (4) @(negedge clk);
    chk("empty", pv, 1'b0);
    ir(`OP_ISP_EXIT);
    chk("isp off", in_system_programming, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
